// [ispf_flash_ctrl.sv]
// ispf_flash_ctrl: in-system flash programming control with AXI4-Lite registers
// assumes one clock, synchronous reset, and that the flash arrays return read
// data with a one-cycle valid strobe
//
// Function
// R1: reboot write with both bits set resets all
// R2: reboot bit reads back reboot in progress
// R3: loader select picks loader array, other reprogrammed
// R4: software sets loader select before enabling
// R5: enable requests core idle during flash operations
// R6: enable clear makes flash read-only
// R7: control register writes need timed-access unlock
// R8: address low, high and data byte registers
// R9: bank select routes reprogramming target array
// R10: loader sets bank select before reprogramming
// R11: strobe bits drive oe, ce and opcode
// R12: reserved bits ignore writes, read zero
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ispf_flash_ctrl (
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	input  wire logic [ispf_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                      s_axi_awprot,
	input  wire logic                            s_axi_awvalid,
	output logic                                 s_axi_awready,
	input  wire logic [31:0]                     s_axi_wdata,
	input  wire logic [3:0]                      s_axi_wstrb,
	input  wire logic                            s_axi_wvalid,
	output logic                                 s_axi_wready,
	output logic [1:0]                           s_axi_bresp,
	output logic                                 s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	input  wire logic [ispf_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                      s_axi_arprot,
	input  wire logic                            s_axi_arvalid,
	output logic                                 s_axi_arready,
	output logic [31:0]                          s_axi_rdata,
	output logic [1:0]                           s_axi_rresp,
	output logic                                 s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	input  wire logic [7:0]                      flash_rdata,
	input  wire logic                            flash_rdata_valid,
	output ispf_pkg::ispf_flash_out_t            flash_out,
	output logic                                 core_idle_request,
	output logic                                 reboot_active
);
	import ispf_pkg::*;

	// register state
	logic                program_enable;
	logic                loader_location_select;
	logic [7:0]          flash_addr_low;
	logic [7:0]          flash_addr_high;
	logic [7:0]          flash_data_byte;
	logic [7:0]          flash_strobe_control;
	ispf_ta_state_t      ta_state;
	logic [CNT_W-1:0]    ta_window;
	ispf_run_state_t     run_state;
	logic [CNT_W-1:0]    reboot_cnt;

	logic                next_program_enable;
	logic                next_loader_location_select;
	logic [7:0]          next_flash_addr_low;
	logic [7:0]          next_flash_addr_high;
	logic [7:0]          next_flash_data_byte;
	logic [7:0]          next_flash_strobe_control;
	ispf_ta_state_t      next_ta_state;
	logic [CNT_W-1:0]    next_ta_window;
	ispf_run_state_t     next_run_state;
	logic [CNT_W-1:0]    next_reboot_cnt;

	// bus state
	logic                bvalid;
	logic [1:0]          bresp;
	logic                rvalid;
	logic [1:0]          rresp;
	logic [7:0]          rdata;
	logic                next_bvalid;
	logic [1:0]          next_bresp;
	logic                next_rvalid;
	logic [1:0]          next_rresp;
	logic [7:0]          next_rdata;

	logic                wr_take;
	logic                rd_take;
	logic [9:0]          wr_idx;
	logic [9:0]          rd_idx;
	logic [7:0]          wr_byte;
	logic                wr_lane0;
	logic                wr_hit;
	logic                rd_hit;
	logic                software_reboot_write;
	logic                software_reboot;

	// write address and data are taken together, so either arrival order works
	assign wr_take       = s_axi_awvalid && s_axi_wvalid && !bvalid;
	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign rd_take       = s_axi_arvalid && !rvalid;
	assign s_axi_arready = rd_take;
	assign wr_idx        = s_axi_awaddr[AXI_ADDR_W-1:2];
	assign rd_idx        = s_axi_araddr[AXI_ADDR_W-1:2];
	assign wr_byte       = s_axi_wdata[7:0];
	assign wr_lane0      = s_axi_wstrb[0];

	// the reboot only fires from loader mode with isp on
	assign software_reboot_write = wr_take && wr_lane0 && (wr_idx == IDX_PROGRAM_CONTROL)
		&& (ta_window != RST_CNT) && wr_byte[PC_REBOOT_BIT]
		&& loader_location_select && program_enable;     // R1
	assign software_reboot = (run_state == RUN_REBOOT);  // R2

	// write decode: known register indices answer okay, the rest error
	always_comb begin
		wr_hit = 1'b0;
		if (wr_idx == IDX_PROGRAM_CONTROL) begin
			wr_hit = 1'b1;
		end else if (wr_idx == IDX_FLASH_ADDR_LOW) begin
			wr_hit = 1'b1;
		end else if (wr_idx == IDX_FLASH_ADDR_HIGH) begin
			wr_hit = 1'b1;
		end else if (wr_idx == IDX_FLASH_DATA_BYTE) begin
			wr_hit = 1'b1;
		end else if (wr_idx == IDX_FLASH_STROBE) begin
			wr_hit = 1'b1;
		end else if (wr_idx == IDX_TIMED_ACCESS) begin
			wr_hit = 1'b1;
		end
	end

	// read decode; reserved bits come back as zero
	always_comb begin
		rd_hit     = 1'b1;
		next_rdata = 8'h00;
		if (rd_idx == IDX_PROGRAM_CONTROL) begin
			next_rdata[PC_REBOOT_BIT] = software_reboot;         // R2
			next_rdata[PC_LOADER_BIT] = loader_location_select;  // R12
			next_rdata[PC_PROGEN_BIT] = program_enable;
		end else if (rd_idx == IDX_FLASH_ADDR_LOW) begin
			next_rdata = flash_addr_low;
		end else if (rd_idx == IDX_FLASH_ADDR_HIGH) begin
			next_rdata = flash_addr_high;
		end else if (rd_idx == IDX_FLASH_DATA_BYTE) begin
			next_rdata = flash_data_byte;
		end else if (rd_idx == IDX_FLASH_STROBE) begin
			next_rdata = flash_strobe_control & FS_WMASK;         // R12
		end else if (rd_idx == IDX_TIMED_ACCESS) begin
			next_rdata = 8'h00;                                   // unlock reads as zero
		end else begin
			rd_hit = 1'b0;
		end
		if (!rd_take) begin
			next_rdata = rdata;
		end
	end

	// bus response next values
	always_comb begin
		next_bvalid = bvalid;
		next_bresp  = bresp;
		next_rvalid = rvalid;
		next_rresp  = rresp;
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (wr_take) begin
			next_bvalid = 1'b1;
			next_bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (rd_take) begin
			next_rvalid = 1'b1;
			next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// bus response registers survive a reboot so a pending answer still completes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp  <= RESP_OKAY;
			rdata  <= RST_BYTE;
		end else begin
			bvalid <= next_bvalid;
			bresp  <= next_bresp;
			rvalid <= next_rvalid;
			rresp  <= next_rresp;
			rdata  <= next_rdata;
		end
	end

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp  = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp  = rresp;
	assign s_axi_rdata  = {24'h000000, rdata};

	// control registers, unlock sequencer and reboot sequencer
	always_comb begin
		next_program_enable         = program_enable;
		next_loader_location_select = loader_location_select;
		next_flash_addr_low         = flash_addr_low;
		next_flash_addr_high        = flash_addr_high;
		next_flash_data_byte        = flash_data_byte;
		next_flash_strobe_control   = flash_strobe_control;
		next_ta_state               = ta_state;
		next_ta_window              = ta_window;
		next_run_state              = run_state;
		next_reboot_cnt             = reboot_cnt;

		// unlock window closes on its own after a fixed time
		if (ta_window != RST_CNT) begin
			next_ta_window = ta_window - 8'h01;
		end

		// flash read data lands in the data byte register
		if (flash_rdata_valid && program_enable) begin
			next_flash_data_byte = flash_rdata;
		end

		if (wr_take && wr_lane0) begin
			if (wr_idx == IDX_TIMED_ACCESS) begin
				// two keys back to back open the window; anything else restarts
				case (ta_state)
					TA_IDLE: begin
						if (wr_byte == TA_KEY1) begin
							next_ta_state = TA_GOT_KEY1;
						end
					end
					TA_GOT_KEY1: begin
						next_ta_state = TA_IDLE;
						if (wr_byte == TA_KEY2) begin
							next_ta_window = CNT_W'(TA_WINDOW_CYC);  // R7
						end
					end
					default: begin
						next_ta_state = TA_IDLE;
					end
				endcase
			end else begin
				next_ta_state = TA_IDLE;
			end
			if (wr_idx == IDX_PROGRAM_CONTROL) begin
				// one write per unlock; a write without it is dropped silently
				if (ta_window != RST_CNT) begin                          // R7
					next_loader_location_select = wr_byte[PC_LOADER_BIT]; // R3
					next_program_enable         = wr_byte[PC_PROGEN_BIT]; // R12
					next_ta_window              = RST_CNT;
				end
			end else if (wr_idx == IDX_FLASH_ADDR_LOW) begin
				next_flash_addr_low = wr_byte;                            // R8
			end else if (wr_idx == IDX_FLASH_ADDR_HIGH) begin
				next_flash_addr_high = wr_byte;                           // R8
			end else if (wr_idx == IDX_FLASH_DATA_BYTE) begin
				next_flash_data_byte = wr_byte;                           // R8
			end else if (wr_idx == IDX_FLASH_STROBE) begin
				next_flash_strobe_control = wr_byte & FS_WMASK;           // R12
			end
		end

		// reboot holds every control register at its reset value
		case (run_state)
			RUN_NORMAL: begin
				if (software_reboot_write) begin
					next_run_state  = RUN_REBOOT;                         // R1
					next_reboot_cnt = CNT_W'(REBOOT_CYC);
				end
			end
			RUN_REBOOT: begin
				next_reboot_cnt = reboot_cnt - 8'h01;
				if (reboot_cnt == 8'h01) begin
					next_run_state = RUN_NORMAL;
				end
			end
			default: begin
				next_run_state = RUN_NORMAL;
			end
		endcase
		if (software_reboot_write || software_reboot) begin
			next_program_enable         = 1'b0;                          // R1
			next_loader_location_select = 1'b0;
			next_flash_addr_low         = RST_BYTE;
			next_flash_addr_high        = RST_BYTE;
			next_flash_data_byte        = RST_BYTE;
			next_flash_strobe_control   = RST_BYTE;
			next_ta_state               = TA_IDLE;
			next_ta_window              = RST_CNT;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			program_enable         <= 1'b0;
			loader_location_select <= 1'b0;
			flash_addr_low         <= RST_BYTE;
			flash_addr_high        <= RST_BYTE;
			flash_data_byte        <= RST_BYTE;
			flash_strobe_control   <= RST_BYTE;
			ta_state               <= TA_IDLE;
			ta_window              <= RST_CNT;
			run_state              <= RUN_NORMAL;
			reboot_cnt             <= RST_CNT;
		end else begin
			program_enable         <= next_program_enable;
			loader_location_select <= next_loader_location_select;
			flash_addr_low         <= next_flash_addr_low;
			flash_addr_high        <= next_flash_addr_high;
			flash_data_byte        <= next_flash_data_byte;
			flash_strobe_control   <= next_flash_strobe_control;
			ta_state               <= next_ta_state;
			ta_window              <= next_ta_window;
			run_state              <= next_run_state;
			reboot_cnt             <= next_reboot_cnt;
		end
	end

	// flash side: address, data and strobes are gated by isp mode so the arrays stay read-only
	// when it is off; strobes are flip-flop bits gated by the program_enable flip-flop
	always_comb begin
		flash_out                = '0;
		flash_out.loader_in_boot = loader_location_select;                        // R3
		flash_out.isp_active     = program_enable;                                // R5
		if (program_enable) begin                                                 // R6
			flash_out.addr        = {flash_addr_high, flash_addr_low};            // R8
			flash_out.wdata       = flash_data_byte;                              // R8
			// bank select high points the write path at the boot array
			flash_out.target_boot = flash_strobe_control[FS_BANK_BIT];            // R9
			flash_out.oe          = flash_strobe_control[FS_OE_BIT];              // R11
			flash_out.ce          = flash_strobe_control[FS_CE_BIT];              // R11
			flash_out.op          = flash_strobe_control[FS_OP_LSB +: 4];         // R11
		end
	end

	// core is asked to idle while isp mode runs the flash
	assign core_idle_request = program_enable;   // R5
	assign reboot_active     = software_reboot;  // R1

endmodule : ispf_flash_ctrl

// [ispf_pkg.sv]
// ispf_pkg: constants, types and register map of the flash programming control
// assumes a 100 MHz core clock and an AXI4-Lite register port with 32-bit data
package ispf_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int TA_WINDOW_NS    = 80;   // unlock stays open this long
	localparam int REBOOT_NS       = 200;  // reboot hold time
	localparam int TA_WINDOW_CYC   = (TA_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REBOOT_CYC      = (REBOOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W           = 8;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_PROGRAM_CONTROL = 10'h0bf;
	localparam logic [9:0] IDX_FLASH_ADDR_LOW  = 10'h0c4;
	localparam logic [9:0] IDX_FLASH_ADDR_HIGH = 10'h0c5;
	localparam logic [9:0] IDX_FLASH_DATA_BYTE = 10'h0c6;
	localparam logic [9:0] IDX_FLASH_STROBE    = 10'h0c7;
	localparam logic [9:0] IDX_TIMED_ACCESS    = 10'h0cf;
	localparam int AXI_ADDR_W = 12;

	// program_control fields
	localparam int PC_REBOOT_BIT  = 7;
	localparam int PC_LOADER_BIT  = 1;
	localparam int PC_PROGEN_BIT  = 0;
	// flash_strobe_control fields
	localparam int FS_BANK_BIT    = 6;
	localparam int FS_OE_BIT      = 5;
	localparam int FS_CE_BIT      = 4;
	localparam int FS_OP_LSB      = 0;
	localparam logic [7:0] FS_WMASK = 8'h7f;
	localparam logic [7:0] PC_WMASK = 8'h03;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [CNT_W-1:0] RST_CNT = 8'h00;

	// timed-access unlock keys
	localparam logic [7:0] TA_KEY1 = 8'haa;
	localparam logic [7:0] TA_KEY2 = 8'h55;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic {TA_IDLE, TA_GOT_KEY1} ispf_ta_state_t;
	typedef enum logic {RUN_NORMAL, RUN_REBOOT} ispf_run_state_t;

	// flash-facing outputs travel together
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        oe;
		logic        ce;
		logic [3:0]  op;
		logic        target_boot;   // 1: boot array is reprogrammed
		logic        loader_in_boot;// 1: loader runs from boot array
		logic        isp_active;
	} ispf_flash_out_t;
endpackage : ispf_pkg

// [ispf_flash_ctrl_props.sv]
// ispf_flash_ctrl_chk: port-level checks of the flash programming control
// assumes one clock, synchronous active-low reset and single-cycle bus answers
`timescale 1ns/100ps
module ispf_flash_ctrl_chk (
	input wire logic                            aclk,
	input wire logic                            aresetn,
	input wire logic                            s_axi_awvalid,
	input wire logic                            s_axi_awready,
	input wire logic                            s_axi_wvalid,
	input wire logic                            s_axi_wready,
	input wire logic [1:0]                      s_axi_bresp,
	input wire logic                            s_axi_bvalid,
	input wire logic                            s_axi_bready,
	input wire logic [ispf_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic                            s_axi_arvalid,
	input wire logic                            s_axi_arready,
	input wire logic [31:0]                     s_axi_rdata,
	input wire logic                            s_axi_rvalid,
	input wire ispf_pkg::ispf_flash_out_t       flash_out,
	input wire logic                            core_idle_request,
	input wire logic                            reboot_active
);
	import ispf_pkg::*;
	logic [CNT_W-1:0] rb_cnt;
	logic [CNT_W-1:0] next_rb_cnt;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// counts reboot cycles so the hold time is checked without a long repetition
	always_comb begin
		next_rb_cnt = reboot_active ? rb_cnt + 8'h01 : 8'h00;
	end
	always_ff @(posedge aclk) begin
		rb_cnt <= aresetn ? next_rb_cnt : 8'h00;
	end
	a_idle_follows_enable: assert property (core_idle_request == flash_out.isp_active)
		else $error("core idle request differs from programming enable");
	a_readonly_strobes: assert property (!flash_out.isp_active |->
		{flash_out.oe, flash_out.ce, flash_out.op, flash_out.target_boot} == 7'h00)
		else $error("flash strobes active with programming off");
	a_readonly_addr: assert property (!flash_out.isp_active |->
		flash_out.addr == 16'h0000 && flash_out.wdata == 8'h00)
		else $error("flash address or data driven with programming off");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> s_axi_bvalid)
		else $error("write response missing one cycle after take");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
		else $error("read answer late or upper bits set");
	a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before acceptance");
	a_reboot_reads: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == {IDX_PROGRAM_CONTROL, 2'b00} |=>
		s_axi_rdata[7] == $past(reboot_active) && s_axi_rdata[6:2] == 5'h00)
		else $error("control read does not show reboot state");
	a_reboot_clears: assert property (reboot_active |-> flash_out == '0)
		else $error("flash controls not held at reset during reboot");
	a_reboot_length: assert property ($fell(reboot_active) |-> rb_cnt == REBOOT_CYC)
		else $error("reboot held for the wrong number of cycles");
	c_reboot: cover property ($rose(reboot_active));
	c_strobe: cover property (flash_out.oe && flash_out.ce);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : ispf_flash_ctrl_chk

bind ispf_flash_ctrl ispf_flash_ctrl_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .flash_out,
	.core_idle_request, .reboot_active);

// [ispf_flash_model.sv]
// ispf_flash_model: behavioural main and boot flash arrays on the strobe side
// assumes reads start on a rising output-and-chip enable pair
`timescale 1ns/100ps
module ispf_flash_model (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire ispf_pkg::ispf_flash_out_t fo,
	output logic [7:0]                     rdata,
	output logic                           rvalid
);
	import ispf_pkg::*;
	logic strobe_q;
	logic next_strobe_q;
	logic next_rvalid;
	logic [7:0] next_rdata;
	// one pulse per strobe; outside it the data bus toggles so stale bytes never match
	always_comb begin
		next_strobe_q = fo.oe & fo.ce;
		next_rvalid = next_strobe_q & ~strobe_q;
		next_rdata = next_rvalid ? fo.addr[7:0] ^ (fo.target_boot ? 8'h3c : 8'hc3) : ~rdata;
	end
	always_ff @(posedge aclk) begin
		strobe_q <= aresetn & next_strobe_q;
		rvalid <= aresetn & next_rvalid;
		rdata <= aresetn ? next_rdata : 8'h00;
	end
endmodule : ispf_flash_model

// [tb_isp_flash_program_control.sv]
// tb_isp_flash_program_control: register-model bench for the flash control
// assumes the flash model answers a strobe two cycles after its write
`timescale 1ns/100ps
module tb_isp_flash_program_control;
	import ispf_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, ul = 1'b0, rb = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, fvalid, idle, rbt;
	logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] fdata;
	ispf_flash_out_t fo;
	int errors = 0, compares = 0, seed = 27798, n;
	logic [7:0] mdl [5];
	logic [9:0] idx [7] = '{IDX_PROGRAM_CONTROL, IDX_FLASH_ADDR_LOW, IDX_FLASH_ADDR_HIGH,
		IDX_FLASH_DATA_BYTE, IDX_FLASH_STROBE, IDX_TIMED_ACCESS, 10'h0c8};
	logic [7:0] msk [5] = '{PC_WMASK, 8'hff, 8'hff, 8'hff, FS_WMASK};
	ispf_flash_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'b000), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.flash_rdata(fdata), .flash_rdata_valid(fvalid), .flash_out(fo),
		.core_idle_request(idle), .reboot_active(rbt));
	ispf_flash_model flash_u (.aclk, .aresetn, .fo, .rdata(fdata), .rvalid(fvalid));
	initial begin
		forever #5 aclk = ~aclk;
	end
	task stop_test;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task to_check(input int k);
		if (k >= 100) begin
			chk("timeout", 1, 0);
			stop_test();
		end
	endtask : to_check
	// bounded wait for a handshake sampled at a rising edge
	task automatic waitfor(ref logic s);
		int k;
		@(posedge aclk);
		for (k = 0; s !== 1'b1 && k < 100; k++) @(posedge aclk);
		to_check(k);
	endtask : waitfor
	task wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= {a, 2'b00};
		wdata <= ($random(seed) << 8) | d; // upper bits are noise the slave must ignore
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		waitfor(awready);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		waitfor(bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= {a, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		waitfor(arready);
		arvalid <= 1'b0;
		waitfor(rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	// write through the model, then compare the flash-side outputs
	task wreg(input int k, input logic [7:0] d);
		logic [1:0] r;
		ispf_flash_out_t e;
		wr(idx[k], d, r);
		chk("bresp", k == 6 ? RESP_SLVERR : RESP_OKAY, r);
		if (k == 0 && ul && d[7] && mdl[0] == 8'h03) begin
			mdl = '{default: 8'h00};
			rb = 1'b1;
		end else if (k == 0 && ul) mdl[0] = d & msk[0];
		else if (k > 0 && k < 5) mdl[k] = d & msk[k];
		if (k == 0) ul = 1'b0;
		e = '0;
		if (mdl[0][0]) begin
			e.addr = {mdl[2], mdl[1]};
			e.wdata = mdl[3];
			{e.oe, e.ce, e.op} = mdl[4][5:0];
			e.target_boot = mdl[4][6];
		end
		e.loader_in_boot = mdl[0][1];
		e.isp_active = mdl[0][0];
		chk("flash_out", e, fo);
		chk("core_idle_request", mdl[0][0], idle);
	endtask : wreg
	task rreg(input int k);
		logic [31:0] d;
		logic [1:0] r;
		rd(idx[k], d, r);
		chk("rresp", k == 6 ? RESP_SLVERR : RESP_OKAY, r);
		if (k < 5) chk("rdata", {rb && k == 0, 7'h00} | mdl[k], d);
	endtask : rreg
	task unlock;
		wreg(5, TA_KEY1);
		wreg(5, TA_KEY2);
		ul = 1'b1;
	endtask : unlock
	initial begin
		mdl = '{default: 8'h00};
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int k = 0; k < 7; k++) rreg(k);
		wreg(6, 8'h5a);
		wreg(0, 8'h03);
		rreg(0);
		unlock();
		wreg(0, 8'h7e);
		rreg(0);
		// programming off: registers hold values but the strobes stay dark
		for (int k = 1; k < 5; k++) begin
			wreg(k, 8'($random(seed)));
			rreg(k);
		end
		wreg(4, 8'hff);
		rreg(4);
		unlock();
		wreg(0, 8'h03);
		// strobes were left on, so the boot array answers as soon as isp turns on
		mdl[3] = mdl[1] ^ 8'h3c;
		// every opcode on both banks, bank chosen before the strobe rises
		for (int i = 0; i < 32; i++) begin
			wreg(1, 8'($random(seed)));
			wreg(2, 8'($random(seed)));
			wreg(4, {1'b0, i[0], 6'h00});
			wreg(4, {1'b0, i[0], 2'b11, i[4:1]});
			mdl[3] = mdl[1] ^ (i[0] ? 8'h3c : 8'hc3);
			rreg(3);
		end
		unlock();
		wreg(0, 8'h01);
		unlock();
		wreg(0, 8'h03);
		unlock();
		wreg(0, 8'h83);
		chk("reboot_active", 1, rbt);
		rreg(0);
		for (n = 0; rbt === 1'b1 && n < 100; n++) @(posedge aclk);
		to_check(n);
		rb = 1'b0;
		for (int k = 0; k < 5; k++) rreg(k);
		stop_test();
	end
endmodule : tb_isp_flash_program_control
